// >>> rtl/qdsc_pkg.sv
package qdsc_pkg;

    // ----------------------------------------
    // frame layout
    // ----------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int DATA_BITS = 12;
    localparam int NUM_CHAN = 4;
    localparam int CHAN_BITS = 2;

    typedef struct packed {
        logic chan_sel_hi;
        logic chan_sel_lo;
        logic ctrl_code_hi;
        logic ctrl_code_lo;
        logic [DATA_BITS-1:0] conv_value;
    } qdsc_frame_t;

    // ----------------------------------------
    // control codes {ctrl_code_hi, ctrl_code_lo}
    // ----------------------------------------
    localparam logic [1:0] CODE_WIDE = 2'h0;
    localparam logic [1:0] CODE_LOAD = 2'h1;
    localparam logic [1:0] CODE_XFER = 2'h2;
    localparam logic [1:0] CODE_LOAD_UPD = 2'h3;
    localparam logic [1:0] ADDR_EDGE_RISE = 2'h3;
    localparam logic [1:0] ADDR_EDGE_FALL = 2'h2;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [DATA_BITS-1:0] RST_CONV = 12'h000;
    localparam logic [FRAME_BITS-1:0] RST_SHIFT = 16'h0000;
    localparam logic RST_PIN_HIGH = 1'b1;

    typedef enum logic {
        EDGE_FALL,
        EDGE_RISE
    } qdsc_edge_t;

    localparam qdsc_edge_t RST_EDGE = EDGE_RISE;

    // ----------------------------------------
    // link timing
    // ----------------------------------------
    localparam int SCLK_MAX_KHZ = 10000;
    localparam int ECHO_DELAY_RISE = FRAME_BITS;

endpackage

// >>> rtl/qdsc_sync.sv
`timescale 1ns/1ns
module qdsc_sync
    import qdsc_pkg::*;
#(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic async_i,
    output logic level_o
);

    // ----------------------------------------
    // three stages, change taken once stage two and three agree
    // ----------------------------------------
    logic st1_q, st2_q, st3_q, lvl_q;
    logic lvl_d;

    always_comb begin
        lvl_d = lvl_q;
        if (st2_q == st3_q) begin
            lvl_d = st3_q;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st1_q <= RST_VAL;
            st2_q <= RST_VAL;
            st3_q <= RST_VAL;
            lvl_q <= RST_VAL;
        end else begin
            st1_q <= async_i;
            st2_q <= st1_q;
            st3_q <= st2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level_o = lvl_q;

endmodule

// >>> rtl/qdsc_top.sv
`timescale 1ns/1ns
// Function
// - frame is sixteen bits, msb first
// - two address, two control, twelve data bits
// - shift serial input on rising edge, select low
// - select high: interface idle, echo high/released
// - shift word reaches registers only at select rising edge
// - code 01 loads addressed input register only
// - code 11 loads input, then updates all outputs
// - code 00, low address 0: broadcast to all
// - code 00, low address 1: skip command
// - code 10, any address: update all outputs
// - code 10 address 11/10 sets echo edge
// - echo delay 16.5 falling, 16 rising
// - rising edge echo launch after power-up
// - strobe low: holding registers transparent
// - strobe high latches; falling strobe copies all
// - echo shows shift register only, no readback
module qdsc_top
    import qdsc_pkg::*;
#(
    parameter int NCH = NUM_CHAN,
    parameter int DW = DATA_BITS,
    parameter bit OPEN_DRAIN = 1'b0
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic sclk_i,
    input wire logic chip_sel_n_i,
    input wire logic serial_in_i,
    input wire logic load_outputs_strobe_n_i,
    output logic echo_out_o,
    output logic echo_oe_o,
    output logic [NCH-1:0][DW-1:0] conv_out_o,
    output logic echo_rise_mode_o
);

    // the frame layout fixes both; other values could never be decoded
    if (NCH != NUM_CHAN || DW != DATA_BITS) begin : g_bad_size
        $error("qdsc_top: channel count and width are fixed by the frame");
    end

    // ----------------------------------------
    // link domain: shift register and echo
    // ----------------------------------------
    logic [FRAME_BITS-1:0] shift_q, shift_d;
    logic echo_fall_q;
    logic mode_s1_q, mode_s2_q;
    qdsc_edge_t mode_q, mode_d;
    logic [4:0] low_run_q, low_run_d;

    // the serial clock may stop outside frames, so nothing here waits on it
    // once select rises; the word stays frozen until the next frame
    always_comb begin
        shift_d = shift_q;
        low_run_d = 5'h00;
        if (!chip_sel_n_i) begin
            shift_d = {shift_q[FRAME_BITS-2:0], serial_in_i};
            low_run_d = low_run_q;
            // checker helper only: select-low edges, saturating at one frame
            if (low_run_q != 5'(FRAME_BITS)) begin
                low_run_d = low_run_q + 5'h01;
            end
        end
    end

    always_ff @(posedge sclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shift_q <= RST_SHIFT;
            low_run_q <= 5'h00;
            mode_s1_q <= RST_PIN_HIGH;
            mode_s2_q <= RST_PIN_HIGH;
        end else begin
            shift_q <= shift_d;
            low_run_q <= low_run_d;
            mode_s1_q <= (mode_q == EDGE_RISE);
            mode_s2_q <= mode_s1_q;
        end
    end

    // half a bit later than the rising launch
    always_ff @(negedge sclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            echo_fall_q <= RST_PIN_HIGH;
        end else begin
            echo_fall_q <= shift_q[FRAME_BITS-1];
        end
    end

    logic echo_bit;

    // only shift register content ever reaches the echo pin
    assign echo_bit = mode_s2_q ? shift_q[FRAME_BITS-1] : echo_fall_q;

    // select gates the pin directly: idle level must hold without clocks
    always_comb begin
        if (OPEN_DRAIN) begin
            echo_out_o = 1'b0;
            echo_oe_o = !chip_sel_n_i && !echo_bit;
        end else begin
            echo_out_o = chip_sel_n_i ? 1'b1 : echo_bit;
            echo_oe_o = 1'b1;
        end
    end

    // ----------------------------------------
    // system domain: pin synchronisers
    // ----------------------------------------
    logic cs_lvl, strobe_lvl;
    logic cs_prev_q;
    logic commit;

    qdsc_sync #(
        .RST_VAL(RST_PIN_HIGH)
    ) u_cs_sync (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .async_i(chip_sel_n_i),
        .level_o(cs_lvl)
    );

    qdsc_sync #(
        .RST_VAL(RST_PIN_HIGH)
    ) u_strobe_sync (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .async_i(load_outputs_strobe_n_i),
        .level_o(strobe_lvl)
    );

    // frozen shift word is safe to read: select has been high for
    // several system cycles before this pulse
    assign commit = cs_lvl && !cs_prev_q;

    qdsc_frame_t frame;
    logic [1:0] code;
    logic [1:0] addr;

    assign frame = qdsc_frame_t'(shift_q);
    assign code = {frame.ctrl_code_hi, frame.ctrl_code_lo};
    assign addr = {frame.chan_sel_hi, frame.chan_sel_lo};

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    logic [NCH-1:0] wr_one;
    logic wr_all, upd_all;

    always_comb begin
        wr_one = '0;
        wr_all = 1'b0;
        upd_all = 1'b0;
        mode_d = mode_q;
        if (commit) begin
            unique case (code)
                CODE_LOAD: begin
                    wr_one[addr] = 1'b1;
                end
                CODE_LOAD_UPD: begin
                    wr_one[addr] = 1'b1;
                    upd_all = 1'b1;
                end
                CODE_WIDE: begin
                    wr_all = !frame.chan_sel_lo;
                end
                CODE_XFER: begin
                    upd_all = 1'b1;
                    if (addr == ADDR_EDGE_RISE) begin
                        mode_d = EDGE_RISE;
                    end else if (addr == ADDR_EDGE_FALL) begin
                        mode_d = EDGE_FALL;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // per channel input and holding registers
    // ----------------------------------------
    logic [NCH-1:0][DW-1:0] in_q, in_d;
    logic [NCH-1:0][DW-1:0] hold_q, hold_d;

    for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
        always_comb begin
            in_d[ch] = in_q[ch];
            hold_d[ch] = hold_q[ch];
            if (wr_one[ch] || wr_all) begin
                in_d[ch] = frame.conv_value;
            end
            if (wr_all) begin
                hold_d[ch] = frame.conv_value;
            end else if (upd_all) begin
                hold_d[ch] = in_d[ch];
            end
            // low strobe: holding follows input, also new commits
            if (!strobe_lvl) begin
                hold_d[ch] = in_d[ch];
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cs_prev_q <= RST_PIN_HIGH;
            in_q <= {NCH{RST_CONV}};
            hold_q <= {NCH{RST_CONV}};
            mode_q <= RST_EDGE;
        end else begin
            cs_prev_q <= cs_lvl;
            in_q <= in_d;
            hold_q <= hold_d;
            mode_q <= mode_d;
        end
    end

    assign conv_out_o = hold_q;
    assign echo_rise_mode_o = (mode_q == EDGE_RISE);

    // ----------------------------------------
    // checks, system domain
    // ----------------------------------------
    default clocking cb_sys @(posedge clk_sys_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_commit(logic [1:0] c);
        commit && code == c;
    endsequence

    sequence s_strobe_high;
        strobe_lvl [*2];
    endsequence

    chk_frame_quiet: assert property (
        !commit |=> $stable(in_q) && $stable(mode_q))
        else $error("registers changed outside a commit");

    chk_load_only: assert property (
        s_strobe_high ##0 s_commit(CODE_LOAD)
        |=> in_q[$past(addr)] == $past(frame.conv_value) && $stable(hold_q))
        else $error("input load touched outputs or missed data");

    chk_load_update: assert property (
        s_strobe_high ##0 s_commit(CODE_LOAD_UPD)
        |=> hold_q == in_q && in_q[$past(addr)] == $past(frame.conv_value))
        else $error("load with update failed");

    chk_broadcast_all: assert property (
        s_commit(CODE_WIDE) ##0 !frame.chan_sel_lo
        |=> hold_q == {NCH{$past(frame.conv_value)}} && in_q == hold_q)
        else $error("broadcast did not reach every register");

    chk_skip_cmd: assert property (
        s_strobe_high ##0 s_commit(CODE_WIDE) ##0 frame.chan_sel_lo
        |=> $stable(in_q) && $stable(hold_q) && $stable(mode_q))
        else $error("skip command changed state");

    chk_update_all: assert property (
        s_commit(CODE_XFER) |=> hold_q == in_q && $stable(in_q))
        else $error("update did not copy inputs");

    chk_edge_sel: assert property (
        s_commit(CODE_XFER) ##0 frame.chan_sel_hi
        |=> echo_rise_mode_o == $past(frame.chan_sel_lo))
        else $error("echo edge not selected");

    chk_transparent: assert property (
        !strobe_lvl [*2] |-> hold_q == in_q)
        else $error("holding registers not transparent");

    chk_latched: assert property (
        s_strobe_high ##0 !commit ##0 !$past(commit) |=> $stable(hold_q))
        else $error("holding registers moved while latched");

    chk_commit_pulse: assert property (
        commit |=> !commit)
        else $error("commit pulse longer than one cycle");

    chk_select_quiet: assert property (
        !cs_lvl |=> $stable(in_q) && $stable(mode_q))
        else $error("registers changed while select low");

    chk_load_others: assert property (
        s_commit(CODE_LOAD) |=> in_q[$past(addr) ^ 2'h1] == $past(in_q[addr ^ 2'h1]))
        else $error("load touched another input register");

    chk_xfer_mode: assert property (
        s_commit(CODE_XFER) ##0 !frame.chan_sel_hi |=> $stable(mode_q))
        else $error("plain update changed the echo edge");

    chk_low_load: assert property (
        !strobe_lvl ##0 s_commit(CODE_LOAD)
        |=> hold_q[$past(addr)] == $past(frame.conv_value))
        else $error("transparent channel missed new data");

    chk_strobe_copy: assert property (
        $fell(strobe_lvl) |=> hold_q == in_q)
        else $error("strobe edge did not copy inputs");

    chk_echo_idle: assert property (
        chip_sel_n_i |-> (OPEN_DRAIN ? !echo_oe_o : echo_out_o && echo_oe_o))
        else $error("echo pin not idle with select high");

    chk_power_edge: assert property (
        @(posedge clk_sys_i) disable iff (1'b0)
        !resetn_i |=> echo_rise_mode_o)
        else $error("reset did not select rising launch");

    // ----------------------------------------
    // checks, link domain
    // ----------------------------------------
    chk_shift_in: assert property (
        @(posedge sclk_i) disable iff (!resetn_i)
        !chip_sel_n_i |=> shift_q[0] == $past(serial_in_i)
            && shift_q[FRAME_BITS-1:1] == $past(shift_q[FRAME_BITS-2:0]))
        else $error("serial bit not shifted in");

    chk_shift_hold: assert property (
        @(posedge sclk_i) disable iff (!resetn_i)
        chip_sel_n_i |=> $stable(shift_q))
        else $error("shift register moved with select high");

    chk_echo_half: assert property (
        @(negedge sclk_i) disable iff (!resetn_i)
        1'b1 |=> echo_fall_q == $past(shift_q[FRAME_BITS-1]))
        else $error("falling echo stage lost a bit");

    chk_echo_delay: assert property (
        @(posedge sclk_i) disable iff (!resetn_i)
        low_run_q == 5'(FRAME_BITS) && mode_s2_q |-> echo_bit == $past(serial_in_i, 16))
        else $error("rising echo not sixteen bits late");

endmodule

// >>> bench/qdsc_host.sv
`timescale 1ns/1ns
module qdsc_host (
    output logic sclk_o,
    output logic chip_sel_n_o,
    output logic serial_o,
    input wire logic echo_i
);
    // serial clock stands low outside frames
    initial begin
        sclk_o = 1'b0;
        chip_sel_n_o = 1'b1;
        serial_o = 1'b0;
    end

    task automatic select(input logic on);
        chip_sel_n_o = ~on;
        #15;
    endtask

    // msb first, bit launched while clock is low, so it is steady at the rise
    task automatic shift(input logic [31:0] w, input int n, output logic [15:0] seen);
        seen = 16'h0000;
        for (int i = n - 1; i >= 0; i--) begin
            serial_o = w[i];
            #8;
            seen = {seen[14:0], echo_i};
            sclk_o = 1'b1;
            #7;
            sclk_o = 1'b0;
        end
        // released line shows the inverse, never a stale copy
        serial_o = ~serial_o;
    endtask
endmodule

// >>> bench/quad_dac_serial_command_interface_test.sv
`timescale 1ns/1ns
module quad_dac_serial_command_interface_test;
    import qdsc_pkg::*;

    logic clk_sys_i;
    logic resetn_i;
    logic load_outputs_strobe_n_i;
    logic sclk_i, chip_sel_n_i, serial_in_i, echo_out_o, echo_oe_o, echo_rise_mode_o;
    logic [NUM_CHAN-1:0][DATA_BITS-1:0] conv_out_o;
    logic [NUM_CHAN-1:0][DATA_BITS-1:0] exp;
    logic [15:0] seen;
    int bad_count = 0;
    int n_compared = 0;

    always #10 clk_sys_i = ~clk_sys_i;

    qdsc_top dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .sclk_i(sclk_i),
        .chip_sel_n_i(chip_sel_n_i), .serial_in_i(serial_in_i),
        .load_outputs_strobe_n_i(load_outputs_strobe_n_i), .echo_out_o(echo_out_o),
        .echo_oe_o(echo_oe_o), .conv_out_o(conv_out_o), .echo_rise_mode_o(echo_rise_mode_o));

    qdsc_host host (.sclk_o(sclk_i), .chip_sel_n_o(chip_sel_n_i), .serial_o(serial_in_i),
        .echo_i(echo_out_o));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [63:0] got, input logic [63:0] want, input string msg);
        n_compared++;
        if (got !== want) begin
            $display("[FAIL] %0t %s got %h want %h", $time, msg, got, want);
            bad_count++;
        end
    endtask

    // commit needs select high for several system cycles before anything is checked
    task automatic cmd(input logic [15:0] w);
        host.select(1'b1);
        host.shift({16'h0000, w}, 16, seen);
        host.select(1'b0);
        repeat (10) @(negedge clk_sys_i);
    endtask

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        bad_count++;
        end_of_test();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        load_outputs_strobe_n_i = 1'b1;
        exp = '0;
        // a real falling edge, so the serial-clock flops reset without a clock
        resetn_i = 1'b1;
        #1;
        resetn_i = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        check(conv_out_o, exp, "reset holding");
        check(echo_rise_mode_o, 1'b1, "reset edge");
        check({echo_out_o, echo_oe_o}, 2'h3, "idle echo");
        $display("test reset done");

        for (int ch = 0; ch < NUM_CHAN; ch++) begin
            cmd({ch[1:0], CODE_LOAD, 12'h5A0 | 12'(ch)});
            check(conv_out_o, exp, "load only");
        end
        cmd({2'h1, CODE_XFER, 12'hABC});
        exp = {12'h5A3, 12'h5A2, 12'h5A1, 12'h5A0};
        check(conv_out_o, exp, "update all");
        cmd({2'h0, CODE_LOAD, 12'h111});
        cmd({2'h2, CODE_LOAD_UPD, 12'h3C3});
        exp = {12'h5A3, 12'h3C3, 12'h5A1, 12'h111};
        check(conv_out_o, exp, "load and update");
        $display("test load done");

        cmd({2'h2, CODE_WIDE, 12'hE07});
        exp = {4{12'hE07}};
        check(conv_out_o, exp, "broadcast");
        cmd({2'h1, CODE_WIDE, 12'h123});
        check(conv_out_o, exp, "skip");
        cmd({2'h1, CODE_LOAD, 12'h777});
        cmd({ADDR_EDGE_FALL, CODE_XFER, 12'h000});
        exp[1] = 12'h777;
        check({conv_out_o, echo_rise_mode_o}, {exp, 1'b0}, "falling mode");
        cmd({ADDR_EDGE_RISE, CODE_XFER, 12'h000});
        check(echo_rise_mode_o, 1'b1, "rising mode");
        $display("test codes done");

        // two bursts with a pause: nothing may move while select stays low
        host.select(1'b1);
        host.shift({24'h0, 8'h0E}, 8, seen);
        repeat (10) @(negedge clk_sys_i);
        check(conv_out_o, exp, "mid frame");
        host.shift({24'h0, 8'h9A}, 8, seen);
        repeat (10) @(negedge clk_sys_i);
        check(conv_out_o, exp, "frame end");
        host.select(1'b0);
        repeat (10) @(negedge clk_sys_i);
        exp = {4{12'hE9A}};
        check(conv_out_o, exp, "two bursts");
        // over-long frame keeps only the final sixteen bits
        host.select(1'b1);
        host.shift({8'h0, 8'h7D, 16'h0246}, 24, seen);
        host.select(1'b0);
        repeat (10) @(negedge clk_sys_i);
        exp = {4{12'h246}};
        check(conv_out_o, exp, "long frame");
        // clocks with select high are ignored and the echo pin stays high
        host.shift({24'h0, 8'hA5}, 8, seen);
        check(seen, 16'h00FF, "idle clocks");
        check(conv_out_o, exp, "idle clocks hold");
        cmd(16'h4000);
        check(seen, 16'h0246, "echo data");
        check(echo_out_o, 1'b1, "echo idle");
        $display("test frames done");

        load_outputs_strobe_n_i = 1'b0;
        repeat (8) @(negedge clk_sys_i);
        cmd({2'h3, CODE_LOAD, 12'hBEE});
        exp[3] = 12'hBEE;
        check(conv_out_o, exp, "transparent");
        load_outputs_strobe_n_i = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        cmd({2'h0, CODE_LOAD, 12'h0F0});
        check(conv_out_o, exp, "latched");
        load_outputs_strobe_n_i = 1'b0;
        repeat (8) @(negedge clk_sys_i);
        exp[0] = 12'h0F0;
        check(conv_out_o, exp, "strobe copy");
        load_outputs_strobe_n_i = 1'b1;
        $display("test strobe done");
        end_of_test();
    end
endmodule
